// >>> common/osdreg_pkg.sv
// Package for the display control register block: offsets, field
// positions, reset values and timing counts.
// Assumes a single 20 MHz clock and an 8-bit register port.
`default_nettype none
package osdreg_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_VPOS = 16'h87f1;
  localparam logic [15:0] ADDR_STATUS = 16'h87f8;
  localparam logic [15:0] ADDR_HSD = 16'h87fc;
  localparam logic [15:0] ADDR_VSD = 16'h87fd;
  localparam logic [15:0] ADDR_SCL = 16'h87fe;
  localparam logic [15:0] ADDR_CFG = 16'h87ff;
  localparam logic [15:0] ADDR_B_START = 16'h87e0;
  localparam logic [15:0] ADDR_B_END = 16'h87e1;
  localparam logic [15:0] ADDR_B_POS = 16'h87e2;
  localparam logic [15:0] ADDR_B_VPOS = 16'h87e3;
  localparam logic [15:0] ADDR_VRANGE = 16'h87e4;
  localparam logic [15:0] ADDR_IRQ_STAT = 16'h87e5;
  localparam logic [15:0] ADDR_IRQ_CLR = 16'h87e6;
  localparam logic [15:0] ADDR_IRQ_EN = 16'h87e7;
  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int ST_BUSY = 7;
  localparam int ST_FIELD = 6;
  localparam int ST_SCROLL_AREA_ON = 5;
  localparam int ST_FLR = 4;
  localparam int CFG_CC = 7;
  localparam int CFG_TXTV = 3;
  localparam int CFG_DRATE = 1;
  localparam int CFG_TWO = 0;
  localparam int VR_SECOND_PAGE_SMOOTHING = 5;
  localparam int VR_FIRST_PAGE_SMOOTHING = 4;
  localparam logic [7:0] STATUS_WR_MASK = 8'h3f;
  localparam logic [7:0] SEVEN_BIT_MASK = 8'h7f;
  localparam logic [7:0] SIX_BIT_MASK = 8'h3f;
  localparam logic [7:0] FOUR_BIT_MASK = 8'h0f;
  localparam logic [7:0] VRANGE_MASK = 8'h3f;
  localparam int IRQ_W = 3;
  localparam int IRQ_FIELD = 0;
  localparam int IRQ_VSHOW = 1;
  localparam int IRQ_IDLE = 2;
  // ---------------------------------------------------------------
  // Alignment codes for the video switch
  // ---------------------------------------------------------------
  localparam logic [2:0] ALIGN_OFF = 3'h0;
  localparam logic [2:0] ALIGN_LEAD = 3'h1;
  localparam logic [2:0] ALIGN_SYNC = 3'h2;
  localparam logic [2:0] ALIGN_LAG = 3'h4;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int XTAL_HZ = 12_000_000;
  localparam int VSD_UNIT_XTAL = 8;
  // Least time, so round up
  localparam int VSD_UNIT_CYCLES =
    (VSD_UNIT_XTAL * CLK_HZ + XTAL_HZ - 1) / XTAL_HZ;
  localparam logic [1:0] PIX_DIV_LAST = 2'h1;
  localparam logic [10:0] CHAR_PX = 11'h00c;
  localparam logic [10:0] QUARTER_PX = 11'h003;
  typedef enum logic [1:0] {
    V_IDLE = 2'b00,
    V_DELAY = 2'b01,
    V_LINES = 2'b11,
    V_SHOW = 2'b10
  } osdreg_vstate_t;
endpackage
`default_nettype wire

// >>> hdl/osdreg_ctrl.sv
// Display control registers with the sync delay and window timing
// that they steer. Assumes sync inputs arrive from pins, active high,
// and an 8-bit register port with read data one cycle after the strobe.
//
// Function
// - Status bit 7 reads busy while memory access could disturb picture.
// - Status bit 6 reads one during even field, zero during odd.
// - Flash flag is read-write; set means flash regions show background.
// - Scroll enable writable; four-bit first scroll row writable and readable.
// - Horizontal timing delayed after hsync by 7-bit count of characters.
// - Vertical timing delayed after vsync by 7-bit count of 8 xtal cycles.
// - Configuration bit selects closed-caption mode, else normal text.
// - 3-bit field aligns video switch: off, lead, coincident, lag.
// - Configuration bit picks horizontal or vertical timing for busy.
// - Configuration bit selects the 100/120 Hz field-rate timing mode.
// - Configuration bit enables dual-page display, else single page.
// - Second page gets quarter-character fine offset and 6-bit start.
// - Second page text area ends at a 6-bit whole-character position.
// - Two independent bits enable smoothing for second and first page.
// - Two 2-bit range fields extend vertical offset for each page.
// - First page 6-bit vertical field sets start lines after vsync.
// - Main area start and end apply to single page or first page.
//
// The implementer's own choice: the address-and-strobe port.
`default_nettype none
module osdreg_ctrl
  import osdreg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Sync pins
  input wire logic hsync_in,
  input wire logic vsync_in,
  // Main area limits from the rest of the register map
  input wire logic [1:0] main_fine_h_offset,
  input wire logic [5:0] main_area_start_col,
  input wire logic [5:0] main_area_end_col,
  // Settings to the display engine
  output logic flash_background_only,
  output logic scroll_area_on,
  output logic [3:0] first_scroll_row,
  output logic [3:0] scroll_top_row,
  output logic caption_mode,
  output logic double_rate_mode,
  output logic two_page_mode,
  output logic [7:0] second_page_pos,
  // Timing to the display engine
  output logic pixel_en,
  output logic page_a_window,
  output logic page_b_window,
  output logic rgb_window,
  output logic video_switch_out,
  output logic smoothing_on,
  output logic busy,
  output logic even_field,
  // Interrupt
  output logic irq
);
  import osdreg_pkg::*;

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [7:0] vpos_ff, status_ff, hsd_ff, vsd_ff, scl_ff, cfg_ff;
  logic [7:0] bstart_ff, bend_ff, bpos_ff, bvpos_ff, vrange_ff;
  logic [IRQ_W-1:0] irq_stat_ff, irq_en_ff;
  logic [7:0] rdata_ff;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire logic wr_vpos = reg_wr && reg_addr == ADDR_VPOS;
  wire logic wr_status = reg_wr && reg_addr == ADDR_STATUS;
  wire logic wr_hsd = reg_wr && reg_addr == ADDR_HSD;
  wire logic wr_vsd = reg_wr && reg_addr == ADDR_VSD;
  wire logic wr_scl = reg_wr && reg_addr == ADDR_SCL;
  wire logic wr_cfg = reg_wr && reg_addr == ADDR_CFG;
  wire logic wr_bstart = reg_wr && reg_addr == ADDR_B_START;
  wire logic wr_bend = reg_wr && reg_addr == ADDR_B_END;
  wire logic wr_bpos = reg_wr && reg_addr == ADDR_B_POS;
  wire logic wr_bvpos = reg_wr && reg_addr == ADDR_B_VPOS;
  wire logic wr_vrange = reg_wr && reg_addr == ADDR_VRANGE;
  wire logic wr_iclr = reg_wr && reg_addr == ADDR_IRQ_CLR;
  wire logic wr_ien = reg_wr && reg_addr == ADDR_IRQ_EN;

  // ---------------------------------------------------------------
  // Sync inputs, two flops each plus an edge-detect flop
  // ---------------------------------------------------------------
  logic [1:0] hs_sync_ff, vs_sync_ff;
  logic hs_prev_ff, vs_prev_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hs_sync_ff <= 2'b00;
      vs_sync_ff <= 2'b00;
      hs_prev_ff <= 1'b0;
      vs_prev_ff <= 1'b0;
    end else begin
      hs_sync_ff <= {hs_sync_ff[0], hsync_in};
      vs_sync_ff <= {vs_sync_ff[0], vsync_in};
      hs_prev_ff <= hs_sync_ff[1];
      vs_prev_ff <= vs_sync_ff[1];
    end
  end
  wire logic hs_rise = hs_sync_ff[1] && !hs_prev_ff;
  wire logic vs_rise = vs_sync_ff[1] && !vs_prev_ff;

  // ---------------------------------------------------------------
  // Pixel enable divider
  // ---------------------------------------------------------------
  logic [1:0] pdiv_ff;
  wire logic pix_tick = double_rate_mode || pdiv_ff == PIX_DIV_LAST;
  wire logic [1:0] nxt_pdiv = pix_tick ? 2'h0 : pdiv_ff + 2'h1;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) pdiv_ff <= 2'h0;
    else pdiv_ff <= nxt_pdiv;
  end
  assign pixel_en = pix_tick;

  // ---------------------------------------------------------------
  // Horizontal position
  // ---------------------------------------------------------------
  function automatic logic [10:0] col_px(input logic [10:0] origin,
                                         input logic [5:0] col,
                                         input logic [1:0] quarter);
    col_px = origin + 11'(col) * CHAR_PX + 11'(quarter) * QUARTER_PX;
  endfunction

  logic [10:0] hcnt_ff;
  wire logic hcnt_full = &hcnt_ff;
  wire logic [10:0] nxt_hcnt = hs_rise ? 11'h000 :
    (pix_tick && !hcnt_full) ? hcnt_ff + 11'h001 : hcnt_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) hcnt_ff <= 11'h000;
    else hcnt_ff <= nxt_hcnt;
  end

  wire logic [10:0] h_origin = 11'(hsd_ff[6:0]) * CHAR_PX;
  wire logic [10:0] a_first = col_px(h_origin, main_area_start_col,
                                     main_fine_h_offset);
  wire logic [10:0] a_last = col_px(h_origin, main_area_end_col, 2'h0);
  wire logic [10:0] b_first = col_px(h_origin, bstart_ff[5:0],
                                     bstart_ff[7:6]);
  wire logic [10:0] b_last = col_px(h_origin, bend_ff[5:0], 2'h0);
  wire logic in_a_cols = hcnt_ff >= a_first && hcnt_ff < a_last;
  wire logic in_b_cols = hcnt_ff >= b_first && hcnt_ff < b_last;

  // ---------------------------------------------------------------
  // Vertical sequence
  // ---------------------------------------------------------------
  osdreg_vstate_t vst_ff, nxt_vst;
  logic [10:0] vdly_ff, nxt_vdly;
  logic [8:0] line_ff, nxt_line;
  logic field_ff;
  wire logic [7:0] a_start_line = {vrange_ff[3:2], vpos_ff[5:0]};
  wire logic [7:0] b_start_line = {vrange_ff[1:0], bvpos_ff[5:0]};
  // software keeps both equal; each page uses its own value
  wire logic [7:0] first_line =
    (two_page_mode && b_start_line < a_start_line) ?
    b_start_line : a_start_line;
  wire logic [10:0] vdly_total =
    11'(vsd_ff[6:0]) * 11'(VSD_UNIT_CYCLES);

  always_comb begin
    nxt_vst = vst_ff;
    nxt_vdly = vdly_ff;
    nxt_line = line_ff;
    case (vst_ff)
      V_IDLE: begin
        nxt_vdly = 11'h000;
      end
      V_DELAY: begin
        if (vdly_ff >= vdly_total) begin
          nxt_vst = V_LINES;
          nxt_line = 9'h000;
        end else begin
          nxt_vdly = vdly_ff + 11'h001;
        end
      end
      V_LINES: begin
        if ({1'b0, first_line} <= line_ff) nxt_vst = V_SHOW;
        else if (hs_rise) nxt_line = line_ff + 9'h001;
      end
      V_SHOW: begin
        if (hs_rise && !(&line_ff)) nxt_line = line_ff + 9'h001;
      end
      default: begin
        nxt_vst = V_IDLE;
      end
    endcase
    if (vs_rise) begin
      nxt_vst = V_DELAY;
      nxt_vdly = 11'h000;
      nxt_line = 9'h000;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vst_ff <= V_IDLE;
      vdly_ff <= 11'h000;
      line_ff <= 9'h000;
    end else begin
      vst_ff <= nxt_vst;
      vdly_ff <= nxt_vdly;
      line_ff <= nxt_line;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) field_ff <= 1'b0;
    else if (vs_rise) field_ff <= !field_ff;
  end
  assign even_field = field_ff;

  // ---------------------------------------------------------------
  // Page windows
  // ---------------------------------------------------------------
  wire logic v_show = vst_ff == V_SHOW;
  wire logic a_rows = v_show && {1'b0, a_start_line} <= line_ff;
  wire logic b_rows = v_show && {1'b0, b_start_line} <= line_ff;
  wire logic win_a = a_rows && in_a_cols;
  // second page only in dual mode
  wire logic win_b = two_page_mode && b_rows && in_b_cols;
  wire logic win_any = win_a || win_b;

  wire logic busy_now = cfg_ff[CFG_TXTV] ? win_any : v_show;

  // one pixel either side of the window
  logic [2:0] wpipe_ff;
  logic busy_ff, vsw_ff, smooth_ff, wa_ff, wb_ff, rgb_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) wpipe_ff <= 3'b000;
    else if (pix_tick) wpipe_ff <= {wpipe_ff[1:0], win_any};
  end

  wire logic vsw_sel =
    (cfg_ff[6:4] == ALIGN_LEAD) ? wpipe_ff[0] :
    (cfg_ff[6:4] == ALIGN_SYNC) ? wpipe_ff[1] :
    (cfg_ff[6:4] == ALIGN_LAG) ? wpipe_ff[2] : 1'b0;
  wire logic smooth_sel = (win_a && vrange_ff[VR_FIRST_PAGE_SMOOTHING]) ||
    (win_b && !win_a && vrange_ff[VR_SECOND_PAGE_SMOOTHING]);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_ff <= 1'b0;
      vsw_ff <= 1'b0;
      smooth_ff <= 1'b0;
      wa_ff <= 1'b0;
      wb_ff <= 1'b0;
      rgb_ff <= 1'b0;
    end else begin
      busy_ff <= busy_now;
      vsw_ff <= vsw_sel;
      smooth_ff <= smooth_sel;
      wa_ff <= win_a;
      wb_ff <= win_b;
      rgb_ff <= wpipe_ff[1];
    end
  end
  assign busy = busy_ff;
  assign video_switch_out = vsw_ff;
  // Same register stage as the switch, so code 010 lines up
  assign rgb_window = rgb_ff;
  assign smoothing_on = smooth_ff;
  assign page_a_window = wa_ff;
  assign page_b_window = wb_ff;

  // ---------------------------------------------------------------
  // Interrupt events
  // ---------------------------------------------------------------
  wire logic [IRQ_W-1:0] irq_evt = {busy_ff && !busy_now,
    vst_ff == V_LINES && nxt_vst == V_SHOW, vs_rise};
  // Set beats clear in the same cycle
  wire logic [IRQ_W-1:0] nxt_irq_stat =
    (irq_stat_ff & ~(wr_iclr ? reg_wdata[IRQ_W-1:0] : '0)) | irq_evt;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_ff <= '0;
      irq_en_ff <= '0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      if (wr_ien) irq_en_ff <= reg_wdata[IRQ_W-1:0];
    end
  end
  assign irq = |(irq_stat_ff & irq_en_ff);

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vpos_ff <= REG_RESET;
      status_ff <= REG_RESET;
      hsd_ff <= REG_RESET;
      vsd_ff <= REG_RESET;
      scl_ff <= REG_RESET;
      cfg_ff <= REG_RESET;
      bstart_ff <= REG_RESET;
      bend_ff <= REG_RESET;
      bpos_ff <= REG_RESET;
      bvpos_ff <= REG_RESET;
      vrange_ff <= REG_RESET;
    end else begin
      if (wr_vpos) vpos_ff <= reg_wdata;
      if (wr_status) status_ff <= reg_wdata & STATUS_WR_MASK;
      if (wr_hsd) hsd_ff <= reg_wdata & SEVEN_BIT_MASK;
      if (wr_vsd) vsd_ff <= reg_wdata & SEVEN_BIT_MASK;
      if (wr_scl) scl_ff <= reg_wdata & FOUR_BIT_MASK;
      if (wr_cfg) cfg_ff <= reg_wdata;
      if (wr_bstart) bstart_ff <= reg_wdata;
      if (wr_bend) bend_ff <= reg_wdata & SIX_BIT_MASK;
      if (wr_bpos) bpos_ff <= reg_wdata;
      if (wr_bvpos) bvpos_ff <= reg_wdata & SIX_BIT_MASK;
      if (wr_vrange) vrange_ff <= reg_wdata & VRANGE_MASK;
    end
  end

  // ---------------------------------------------------------------
  // Settings out
  // ---------------------------------------------------------------
  assign flash_background_only = status_ff[ST_FLR];
  assign scroll_area_on = status_ff[ST_SCROLL_AREA_ON];
  assign first_scroll_row = status_ff[3:0];
  assign scroll_top_row = scl_ff[3:0];
  assign caption_mode = cfg_ff[CFG_CC];
  assign double_rate_mode = cfg_ff[CFG_DRATE];
  assign two_page_mode = cfg_ff[CFG_TWO];
  assign second_page_pos = bpos_ff;

  // ---------------------------------------------------------------
  // Register reads, data one cycle after the strobe
  // ---------------------------------------------------------------
  // busy and field share the status byte
  wire logic [7:0] status_rd = {busy_ff, field_ff, status_ff[5:0]};
  wire logic [7:0] rd_mux =
    (reg_addr == ADDR_VPOS) ? vpos_ff :
    (reg_addr == ADDR_STATUS) ? status_rd :
    (reg_addr == ADDR_HSD) ? hsd_ff :
    (reg_addr == ADDR_VSD) ? vsd_ff :
    (reg_addr == ADDR_SCL) ? scl_ff :
    (reg_addr == ADDR_CFG) ? cfg_ff :
    (reg_addr == ADDR_B_START) ? bstart_ff :
    (reg_addr == ADDR_B_END) ? bend_ff :
    (reg_addr == ADDR_B_POS) ? bpos_ff :
    (reg_addr == ADDR_B_VPOS) ? bvpos_ff :
    (reg_addr == ADDR_VRANGE) ? vrange_ff :
    (reg_addr == ADDR_IRQ_STAT) ? 8'(irq_stat_ff) :
    (reg_addr == ADDR_IRQ_EN) ? 8'(irq_en_ff) : 8'h00;
  // Holding zero outside a read keeps the bus quiet
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rdata_ff <= 8'h00;
    else rdata_ff <= reg_rd ? rd_mux : 8'h00;
  end
  assign reg_rdata = rdata_ff;
endmodule
`default_nettype wire

// >>> verif/osdreg_ctrl_sva.sv
// Checker for the display control register block.
// Assumes it is bound to osdreg_ctrl and sees only its ports.
`default_nettype none
module osdreg_ctrl_sva
  import osdreg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Engine side
  input wire logic vsync_in,
  input wire logic flash_background_only,
  input wire logic scroll_area_on,
  input wire logic [3:0] first_scroll_row,
  input wire logic caption_mode,
  input wire logic double_rate_mode,
  input wire logic two_page_mode,
  input wire logic pixel_en,
  input wire logic page_b_window,
  input wire logic video_switch_out,
  input wire logic busy,
  input wire logic even_field,
  input wire logic irq
);
  // ---------------------------------------------------------------
  // Shadow of the alignment field, not visible at the ports
  // ---------------------------------------------------------------
  logic [2:0] align_ff;
  logic [2:0] nxt_align;
  logic cfg_wr;
  assign cfg_wr = reg_wr && reg_addr == ADDR_CFG;
  assign nxt_align = cfg_wr ? reg_wdata[6:4] : align_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      align_ff <= ALIGN_OFF;
    else
      align_ff <= nxt_align;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  status_read_a: assert property (
    reg_rd && reg_addr == ADDR_STATUS |=> reg_rdata == {$past(busy),
    $past(even_field), $past(scroll_area_on),
    $past(flash_background_only), $past(first_scroll_row)})
    else $error("status read data wrong");
  status_write_a: assert property (
    reg_wr && reg_addr == ADDR_STATUS |=> {2'b00, scroll_area_on,
    flash_background_only, first_scroll_row}
    == ($past(reg_wdata) & STATUS_WR_MASK))
    else $error("status write not applied");
  field_toggle_a: assert property (
    $rose(vsync_in) |-> ##[1:6] $changed(even_field))
    else $error("field flag did not toggle");
  cfg_write_a: assert property (
    cfg_wr |=> {caption_mode, double_rate_mode, two_page_mode}
    == {$past(reg_wdata[7]), $past(reg_wdata[1:0])})
    else $error("configuration write not applied");
  cfg_read_a: assert property (
    reg_rd && reg_addr == ADDR_CFG |=> reg_rdata[7] == $past(caption_mode)
    && reg_rdata[6:4] == $past(align_ff) && reg_rdata[1:0]
    == {$past(double_rate_mode), $past(two_page_mode)})
    else $error("configuration read data wrong");
  fast_pixel_a: assert property (
    double_rate_mode [*3] |-> pixel_en)
    else $error("pixel enable missing at double rate");
  slow_pixel_a: assert property (
    !double_rate_mode && !$past(double_rate_mode) && $past(pixel_en)
    |-> !pixel_en)
    else $error("pixel enable too fast at normal rate");
  page_b_off_a: assert property (
    !two_page_mode && !$past(two_page_mode) |-> !page_b_window)
    else $error("second page shown in single page mode");
  switch_off_a: assert property (
    (align_ff == ALIGN_OFF) [*8] |-> !video_switch_out)
    else $error("video switch active while off");
  irq_mask_a: assert property (
    reg_wr && reg_addr == ADDR_IRQ_EN && reg_wdata[2:0] == 3'h0 |=> !irq)
    else $error("interrupt not masked");
endmodule
bind osdreg_ctrl osdreg_ctrl_sva u_sva (.clk, .rstn, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .vsync_in, .flash_background_only,
  .scroll_area_on, .first_scroll_row, .caption_mode, .double_rate_mode,
  .two_page_mode, .pixel_en, .page_b_window, .video_switch_out, .busy,
  .even_field, .irq);
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the display control register block.
// Assumes the package, the bound checker and one 20 MHz clock.
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  err_total++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb_top
  import osdreg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, reg_wr, reg_rd, hsync_in, vsync_in;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_val, wdat, second_page_pos;
  logic [1:0] main_fine_h_offset;
  logic [5:0] main_area_start_col, main_area_end_col;
  logic flash_background_only, scroll_area_on, caption_mode;
  logic double_rate_mode, two_page_mode, pixel_en, page_a_window;
  logic page_b_window, rgb_window, video_switch_out, smoothing_on;
  logic busy, even_field, irq, exp_field, seen_sw, seen_busy, seen_b;
  logic seen_a, seen_sm, sm_bad, al_bad, busy_bad;
  logic [2:0] cur_code;
  logic [7:0] vr_cur;
  logic [3:0] first_scroll_row, scroll_top_row, pix_n;
  logic [31:0] lfsr_ff;
  logic [2:0] codes [4] = '{ALIGN_OFF, ALIGN_LEAD, ALIGN_SYNC, ALIGN_LAG};
  logic [15:0] addr_tab [10] = '{ADDR_VPOS, ADDR_HSD, ADDR_VSD, ADDR_SCL,
    ADDR_CFG, ADDR_B_START, ADDR_B_END, ADDR_B_POS, ADDR_B_VPOS,
    ADDR_VRANGE};
  logic [7:0] mask_tab [10] = '{8'hff, SEVEN_BIT_MASK, SEVEN_BIT_MASK,
    FOUR_BIT_MASK, 8'hff, 8'hff, SIX_BIT_MASK, 8'hff, SIX_BIT_MASK,
    VRANGE_MASK};
  int err_total, checks_done;
  osdreg_ctrl uut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .hsync_in, .vsync_in, .main_fine_h_offset,
    .main_area_start_col, .main_area_end_col, .flash_background_only,
    .scroll_area_on, .first_scroll_row, .scroll_top_row, .caption_mode,
    .double_rate_mode, .two_page_mode, .second_page_pos, .pixel_en,
    .page_a_window, .page_b_window, .rgb_window, .video_switch_out,
    .smoothing_on, .busy, .even_field, .irq);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_rb(input int i, input logic [7:0] d);
    return d & mask_tab[i];
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask
  // Sync path has 3 clocks of latency, so 8 idle clocks are ample
  task automatic vpulse();
    @(posedge clk);
    vsync_in <= 1'b1;
    repeat (4) @(posedge clk);
    vsync_in <= 1'b0;
    repeat (8) @(posedge clk);
    exp_field = ~exp_field;
    #1;
  endtask
  task automatic line_scan();
    @(posedge clk);
    hsync_in <= 1'b1;
    repeat (300) begin
      @(posedge clk);
      hsync_in <= 1'b0;
      #1;
      seen_sw |= video_switch_out;
      seen_busy |= busy;
      seen_b |= page_b_window;
      seen_a |= page_a_window;
      seen_sm |= smoothing_on;
      sm_bad |= smoothing_on != ((page_a_window && vr_cur[VR_FIRST_PAGE_SMOOTHING]) ||
        (page_b_window && vr_cur[VR_SECOND_PAGE_SMOOTHING]));
      al_bad |= cur_code == ALIGN_SYNC && video_switch_out != rgb_window;
      busy_bad |= busy != (page_a_window || page_b_window);
    end
  endtask
  task automatic pix_count();
    pix_n = 4'h0;
    repeat (8) begin
      @(posedge clk);
      #1;
      pix_n = pix_n + pixel_en;
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {rstn, reg_wr, reg_rd, hsync_in, vsync_in} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    main_fine_h_offset = 2'h1;
    main_area_start_col = 6'h01;
    main_area_end_col = 6'h06;
    lfsr_ff = 32'h0000_30fa;
    exp_field = 1'b0;
    err_total = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    foreach (addr_tab[i]) begin
      rd(addr_tab[i]);
      `CHK(rd_val, REG_RESET)
    end
    // All ones and all zeros first, then random data
    for (int r = 0; r < 6; r++) begin
      foreach (addr_tab[i]) begin
        lfsr_ff = lfsr_next(lfsr_ff);
        wdat = (r == 0) ? 8'hff : (r == 1) ? 8'h00 : lfsr_ff[7:0];
        wr(addr_tab[i], wdat);
        if (addr_tab[i] == ADDR_CFG)
          `CHK({caption_mode, double_rate_mode, two_page_mode},
            {wdat[7], wdat[1:0]})
        if (addr_tab[i] == ADDR_SCL)
          `CHK(scroll_top_row, wdat[3:0])
        if (addr_tab[i] == ADDR_B_POS)
          `CHK(second_page_pos, wdat)
        rd(addr_tab[i]);
        `CHK(rd_val, exp_rb(i, wdat))
      end
    end
    wr(ADDR_STATUS, 8'hff);
    `CHK({scroll_area_on, flash_background_only, first_scroll_row},
      6'h3f)
    rd(ADDR_STATUS);
    `CHK(rd_val[6:0], {exp_field, 6'h3f})
    wr(16'h87f9, 8'h5a);
    rd(16'h87f9);
    `CHK(rd_val, 8'h00)
    rd(ADDR_IRQ_CLR);
    `CHK(rd_val, 8'h00)
    wr(ADDR_CFG, 8'h02);
    pix_count();
    `CHK(pix_n, 4'h8)
    wr(ADDR_CFG, 8'h00);
    pix_count();
    `CHK(pix_n, 4'h4)
    wr(ADDR_IRQ_CLR, 8'hff);
    wr(ADDR_IRQ_EN, 8'h01);
    `CHK(irq, 1'b0)
    vpulse();
    `CHK(even_field, exp_field)
    `CHK(irq, 1'b1)
    rd(ADDR_IRQ_STAT);
    `CHK(rd_val[0], 1'b1)
    wr(ADDR_IRQ_EN, 8'h00);
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_EN, 8'h01);
    `CHK(irq, 1'b1)
    wr(ADDR_IRQ_CLR, 8'h01);
    `CHK(irq, 1'b0)
    // Frame with both pages visible from the first line
    wr(ADDR_VSD, 8'h00);
    wr(ADDR_VPOS, 8'h00);
    wr(ADDR_B_VPOS, 8'h00);
    wr(ADDR_HSD, 8'h01);
    wr(ADDR_B_START, 8'h48);
    wr(ADDR_B_END, 8'h0b);
    foreach (codes[k]) begin
      cur_code = codes[k];
      vr_cur = {2'b00, k[1:0], 4'h0};
      wr(ADDR_VRANGE, vr_cur);
      wr(ADDR_CFG, {1'b0, codes[k], 4'b1001});
      wr(ADDR_IRQ_CLR, 8'hff);
      {seen_sw, seen_busy, seen_b} = 3'b000;
      {seen_a, seen_sm, sm_bad, al_bad, busy_bad} = 5'b00000;
      vpulse();
      rd(ADDR_STATUS);
      `CHK(rd_val[6], exp_field)
      repeat (3) line_scan();
      `CHK(seen_sw, codes[k] != ALIGN_OFF)
      `CHK(seen_busy, 1'b1)
      `CHK(seen_b, 1'b1)
      `CHK(seen_a, 1'b1)
      `CHK(seen_sm, k != 0)
      `CHK(sm_bad, 1'b0)
      `CHK(al_bad, 1'b0)
      `CHK(busy_bad, 1'b0)
      rd(ADDR_IRQ_STAT);
      `CHK(rd_val, 8'h07)
    end
    // Vertical busy source, one delay unit after vsync
    wr(ADDR_VSD, 8'h01);
    wr(ADDR_CFG, 8'h00);
    vpulse();
    `CHK(busy, 1'b0)
    repeat (10) @(posedge clk);
    #1;
    `CHK(busy, 1'b1)
    print_verdict();
  end
endmodule
`default_nettype wire
